// *** rtl/gpt_chan_if.sv ***
// Purpose: Carries counter state to one channel and its results back
// Assumes: Same clock as the timer core
// Notes:   One instance per channel
interface gpt_chan_if #(parameter int CW = 16);
    logic [CW-1:0]       count;
    logic [CW-1:0]       compare;
    logic                tick;
    logic                pulseActive;
    logic                pin;
    gpt_pkg::gpt_chmode_e mode;
    gpt_pkg::gpt_edge_e   edgeSel;
    logic [CW-1:0]       captureVal;
    logic                out;
    logic                event_;

    modport timer (output count, compare, tick, pulseActive, pin, mode, edgeSel,
                   input captureVal, out, event_);
    modport chan  (input count, compare, tick, pulseActive, pin, mode, edgeSel,
                   output captureVal, out, event_);
endinterface : gpt_chan_if

// *** rtl/gpt_channel.sv ***
// Purpose: One capture/compare channel
// Assumes: Pin is synchronous to the clock
// Notes:   Event is a one-cycle registered pulse
module gpt_channel #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic  clock,
    input wire logic  reset,
    // Timer side
    gpt_chan_if.chan  ch
);
    import gpt_pkg::*;

    logic          pinQ;
    logic          outQ;
    logic          eventQ;
    logic [CW-1:0] capQ;
    logic          edgeHit;
    logic          match;

    // Edge detect on the channel pin
    always_comb begin
        unique case (ch.edgeSel)
            GPT_EDGE_RISE: edgeHit = ch.pin & ~pinQ;
            GPT_EDGE_FALL: edgeHit = ~ch.pin & pinQ;
            GPT_EDGE_BOTH: edgeHit = ch.pin ^ pinQ;
            GPT_EDGE_NONE: edgeHit = 1'b0;
        endcase
    end

    assign match = ch.tick & (ch.count == ch.compare);

    // Previous pin level
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pinQ <= 1'b0;
        end else begin
            pinQ <= ch.pin;
        end
    end

    // Capture register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            capQ <= '0;
        end else if (ch.mode == GPT_CH_CAPTURE && edgeHit) begin
            capQ <= ch.count;
        end
    end

    // Channel event pulse
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            eventQ <= 1'b0;
        end else if (ch.mode == GPT_CH_CAPTURE) begin
            eventQ <= edgeHit;
        end else begin
            eventQ <= match;
        end
    end

    // Output waveform per mode
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            outQ <= 1'b0;
        end else begin
            unique case (ch.mode)
                GPT_CH_CAPTURE: outQ <= 1'b0;
                GPT_CH_COMPARE: outQ <= outQ ^ match;
                GPT_CH_PWM:     outQ <= (ch.count < ch.compare);
                GPT_CH_PULSE:   outQ <= ch.pulseActive & (ch.count >= ch.compare);
            endcase
        end
    end

    assign ch.captureVal = capQ;
    assign ch.out        = outQ;
    assign ch.event_     = eventQ;

endmodule : gpt_channel

// *** rtl/gpt_pkg.sv ***
// Purpose: Shared constants and types for the general purpose timer
// Assumes: One clock domain; configuration arrives on plain input ports
// Notes:   Rules below bind the timer core
// Operation
// - Full timer: 16-bit reloadable up/down/center counter
// - Wide configuration: same timer, 32-bit counter
// - 16-bit prescaler divides counter clock
// - Four channels: capture, compare, PWM, one-pulse
// - Trigger in/out links peer timers
// - Debug halt with freeze stops counter; a peer reset trigger still loads it
// - Own DMA requests for update and channels
// - Quadrature encoder drives counter up or down
// - One to three hall inputs, transitions detected
// - Smallest variant: up-only, one channel
// - Middle variant: up/down, two channels
// - Reduced variants count slow crystal clock
package gpt_pkg;

    localparam int PSC_W      = 16;   // Prescaler width
    localparam int CNT_W_STD  = 16;   // Standard counter width
    localparam int CNT_W_WIDE = 32;   // Wide configuration width
    localparam int NUM_CH_STD = 4;    // Full-featured channel count
    localparam int HALL_W     = 3;    // Hall sensor inputs
    localparam logic RUN_RESET = 1'b0;
    localparam logic DIR_UP    = 1'b1;

    // Counting modes
    typedef enum logic [1:0] {
        GPT_CNT_UP     = 2'b00,
        GPT_CNT_DOWN   = 2'b01,
        GPT_CNT_CENTER = 2'b10,
        GPT_CNT_ENC    = 2'b11
    } gpt_cntmode_e;

    // Channel modes
    typedef enum logic [1:0] {
        GPT_CH_CAPTURE = 2'b00,
        GPT_CH_COMPARE = 2'b01,
        GPT_CH_PWM     = 2'b10,
        GPT_CH_PULSE   = 2'b11
    } gpt_chmode_e;

    // Capture edge choice
    typedef enum logic [1:0] {
        GPT_EDGE_RISE = 2'b00,
        GPT_EDGE_FALL = 2'b01,
        GPT_EDGE_BOTH = 2'b10,
        GPT_EDGE_NONE = 2'b11
    } gpt_edge_e;

    // Reaction to the peer trigger input
    typedef enum logic [1:0] {
        GPT_SLV_OFF   = 2'b00,
        GPT_SLV_RESET = 2'b01,
        GPT_SLV_START = 2'b10,
        GPT_SLV_GATED = 2'b11
    } gpt_slave_e;

endpackage : gpt_pkg

// *** rtl/gpt_timer.sv ***
// Purpose: General purpose timer core with prescaler and channels
// Assumes: All inputs but slowCrystalClock synchronous to clock; configuration held steady
// Notes:   Variant chosen by parameters CW, NUM_CH, UPDOWN_EN, FULL_EN
module gpt_timer #(
    parameter int CW        = gpt_pkg::CNT_W_STD,
    parameter int NUM_CH    = gpt_pkg::NUM_CH_STD,
    parameter bit UPDOWN_EN = 1'b1,
    parameter bit FULL_EN   = 1'b1
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      reset,
    // Run control
    input  wire logic                      startPulse,
    input  wire logic                      stopPulse,
    input  wire logic                      onePulse,
    input  wire gpt_pkg::gpt_cntmode_e     countMode,
    input  wire logic [gpt_pkg::PSC_W-1:0] prescale,
    input  wire logic [CW-1:0]             period,
    // Clock source
    input  wire logic                      slowClockSel,
    input  wire logic                      slowCrystalClock,
    // Debug freeze
    input  wire logic                      debugHalt,
    input  wire logic                      freezeOnHalt,
    // Peer link
    input  wire logic                      triggerIn,
    input  wire gpt_pkg::gpt_slave_e       slaveMode,
    input  wire logic                      triggerOutSel,
    output logic                           triggerOut,
    // Encoder and hall
    input  wire logic                      encA,
    input  wire logic                      encB,
    input  wire logic [gpt_pkg::HALL_W-1:0] hallIn,
    input  wire logic [gpt_pkg::HALL_W-1:0] hallEnable,
    output logic                           hallEvent,
    // Channels
    input  wire gpt_pkg::gpt_chmode_e      chMode [NUM_CH],
    input  wire gpt_pkg::gpt_edge_e        chEdge [NUM_CH],
    input  wire logic [NUM_CH-1:0][CW-1:0] chCompare,
    input  wire logic [NUM_CH-1:0]         chPin,
    output logic      [NUM_CH-1:0]         chOut,
    output logic      [NUM_CH-1:0][CW-1:0] chCapture,
    // Flags and DMA
    input  wire logic [NUM_CH:0]           flagClear,
    output logic      [NUM_CH:0]           eventFlag,
    input  wire logic [NUM_CH:0]           dmaEnable,
    output logic      [NUM_CH:0]           dmaReq,
    // Status
    output logic      [CW-1:0]             count,
    output logic                           countingUp,
    output logic                           running
);
    import gpt_pkg::*;

    logic [CW-1:0]    cntQ;
    logic [CW-1:0]    cntD;
    logic             dirQ;
    logic             dirD;
    logic             runQ;
    logic [PSC_W-1:0] pscQ;
    logic             slowS1Q;
    logic             slowS2Q;
    logic             slowPrevQ;
    logic             trigPrevQ;
    logic             encAQ;
    logic             encBQ;
    logic [HALL_W-1:0] hallQ;
    logic [HALL_W-1:0] hallChange;
    logic             hallEvtQ;
    logic             updQ;
    logic             trigOutQ;
    logic [NUM_CH:0]  flagQ;
    logic [NUM_CH:0]  dmaQ;
    logic             srcEvent;
    logic             frozen;
    logic             gateOk;
    logic             tick;
    logic             advance;
    logic             upd;
    logic             trigRise;
    logic             encStep;
    logic             encUp;
    logic             encOn;
    gpt_cntmode_e     modeEff;
    logic [NUM_CH-1:0] chEvent;

    // Next value counting up, wrapping to zero past the period
    function automatic logic [CW-1:0] nextUp(input logic [CW-1:0] value,
                                             input logic [CW-1:0] top);
        return (value >= top) ? '0 : value + 1'b1;
    endfunction : nextUp

    // Next value counting down, reloading the period below zero
    function automatic logic [CW-1:0] nextDown(input logic [CW-1:0] value,
                                               input logic [CW-1:0] top);
        return (value == '0) ? top : value - 1'b1;
    endfunction : nextDown

    // Smallest variant counts up only
    assign modeEff = UPDOWN_EN ? countMode : GPT_CNT_UP;

    // Slow crystal clock sync and edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            slowS1Q   <= 1'b0;
            slowS2Q   <= 1'b0;
            slowPrevQ <= 1'b0;
        end else begin
            slowS1Q   <= slowCrystalClock;
            slowS2Q   <= slowS1Q;
            slowPrevQ <= slowS2Q;
        end
    end

    assign srcEvent = slowClockSel ? (slowS2Q & ~slowPrevQ) : 1'b1;
    assign frozen   = freezeOnHalt & debugHalt;
    assign trigRise = triggerIn & ~trigPrevQ;
    assign gateOk   = (slaveMode != GPT_SLV_GATED) | triggerIn;
    assign advance  = runQ & gateOk & ~frozen & srcEvent;
    assign tick     = advance & (pscQ == prescale);

    // Prescaler divides by prescale plus one
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pscQ <= '0;
        end else if (advance) begin
            pscQ <= (pscQ == prescale) ? '0 : pscQ + 1'b1;
        end
    end

    // Encoder sampling and decode
    assign encOn   = FULL_EN && (modeEff == GPT_CNT_ENC);
    assign encStep = encOn & runQ & ~frozen & ((encA ^ encAQ) | (encB ^ encBQ));
    assign encUp   = encA ^ encBQ;

    // Encoder and trigger history
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            encAQ     <= 1'b0;
            encBQ     <= 1'b0;
            trigPrevQ <= 1'b0;
        end else begin
            encAQ     <= encA;
            encBQ     <= encB;
            trigPrevQ <= triggerIn;
        end
    end

    // Next counter value and update event
    always_comb begin
        cntD = cntQ;
        dirD = dirQ;
        upd  = 1'b0;
        if (FULL_EN && slaveMode == GPT_SLV_RESET && trigRise) begin
            cntD = (modeEff == GPT_CNT_DOWN) ? period : '0;
            upd  = 1'b1;
        end else if (encOn) begin
            if (encStep) begin
                dirD = encUp;
                if (encUp) begin
                    cntD = nextUp(cntQ, period);
                    upd  = (cntQ >= period);
                end else begin
                    cntD = nextDown(cntQ, period);
                    upd  = (cntQ == '0);
                end
            end
        end else if (tick) begin
            unique case (modeEff)
                GPT_CNT_UP: begin
                    dirD = DIR_UP;
                    cntD = nextUp(cntQ, period);
                    upd  = (cntQ >= period);
                end
                GPT_CNT_DOWN: begin
                    dirD = ~DIR_UP;
                    cntD = nextDown(cntQ, period);
                    upd  = (cntQ == '0);
                end
                GPT_CNT_CENTER: begin
                    if (dirQ) begin
                        cntD = cntQ + 1'b1;
                        if (cntD >= period) begin
                            dirD = ~DIR_UP;
                            upd  = 1'b1;
                        end
                    end else begin
                        cntD = cntQ - 1'b1;
                        if (cntQ <= 1) begin
                            dirD = DIR_UP;
                            upd  = 1'b1;
                        end
                    end
                end
                default: begin
                    cntD = cntQ;
                end
            endcase
        end
    end

    // Counter and direction
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cntQ <= '0;
            dirQ <= DIR_UP;
        end else begin
            cntQ <= cntD;
            dirQ <= dirD;
        end
    end

    // Run state: start, trigger start, stop, one-pulse end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            runQ <= RUN_RESET;
        end else if (stopPulse || (onePulse && upd && runQ)) begin
            runQ <= 1'b0;
        end else if (startPulse || (slaveMode == GPT_SLV_START && trigRise)) begin
            runQ <= 1'b1;
        end
    end

    // Enabled hall inputs that moved this cycle
    assign hallChange = (hallIn ^ hallQ) & hallEnable;

    // Hall transition detect
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hallQ    <= '0;
            hallEvtQ <= 1'b0;
        end else begin
            hallQ    <= hallIn;
            hallEvtQ <= FULL_EN && (|hallChange);
        end
    end

    // Channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            gpt_chan_if #(.CW(CW)) chIf ();

            // Counter state out, results back
            assign chIf.count       = cntQ;
            assign chIf.compare     = chCompare[gi];
            assign chIf.tick        = tick;
            assign chIf.pulseActive = runQ & onePulse;
            assign chIf.pin         = chPin[gi];
            assign chIf.mode        = chMode[gi];
            assign chIf.edgeSel     = chEdge[gi];
            assign chOut[gi]        = chIf.out;
            assign chCapture[gi]    = chIf.captureVal;
            assign chEvent[gi]      = chIf.event_;

            gpt_channel #(.CW(CW)) u_ch (
                .clock (clock),
                .reset (reset),
                .ch    (chIf.chan)
            );
        end
    endgenerate

    // Update pulse and trigger output
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            updQ     <= 1'b0;
            trigOutQ <= 1'b0;
        end else begin
            updQ     <= upd;
            trigOutQ <= triggerOutSel ? chEvent[0] : upd;
        end
    end

    // Sticky flags, set wins over clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flagQ <= '0;
        end else begin
            flagQ <= (flagQ & ~flagClear) | {chEvent, updQ};
        end
    end

    // DMA requests, full variants only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dmaQ <= '0;
        end else begin
            dmaQ <= FULL_EN ? ({chEvent, updQ} & dmaEnable) : '0;
        end
    end

    assign triggerOut = trigOutQ;
    assign hallEvent  = hallEvtQ;
    assign eventFlag  = flagQ;
    assign dmaReq     = dmaQ;
    assign count      = cntQ;
    assign countingUp = dirQ;
    assign running    = runQ;

endmodule : gpt_timer

// *** test/gpt_far_model.sv ***
// Purpose: Quadrature encoder standing at the timer's far side
// Assumes: Step requests several clocks apart
// Notes:   Gray sequence, line A leads when stepping up
module gpt_far_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Step requests
    input  wire logic stepUp,
    input  wire logic stepDn,
    // Encoder lines
    output logic      encA,
    output logic      encB
);
    logic [1:0] phase_q;
    // Phase moves one state per request
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_q <= 2'h0;
        end else if (stepUp) begin
            phase_q <= phase_q + 2'h1;
        end else if (stepDn) begin
            phase_q <= phase_q - 2'h1;
        end
    end
    // Gray code from phase
    assign encA = phase_q[1] ^ phase_q[0];
    assign encB = phase_q[1];
endmodule : gpt_far_model

// *** test/gpt_timer_chk.sv ***
// Purpose: Port-level checks on the general purpose timer
// Assumes: One clock, async active-high reset
// Notes:   Bound to every gpt_timer instance
module gpt_timer_chk #(
    parameter int CW     = 16,
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic                       clock,
    input wire logic                       reset,
    // Configuration
    input wire logic                       onePulse,
    input wire gpt_pkg::gpt_cntmode_e      countMode,
    input wire logic [gpt_pkg::PSC_W-1:0]  prescale,
    input wire logic [CW-1:0]              period,
    input wire logic                       slowClockSel,
    input wire logic                       debugHalt,
    input wire logic                       freezeOnHalt,
    input wire gpt_pkg::gpt_slave_e        slaveMode,
    input wire gpt_pkg::gpt_chmode_e       chMode [NUM_CH],
    input wire gpt_pkg::gpt_edge_e         chEdge [NUM_CH],
    // Pins and flags
    input wire logic                       triggerIn,
    input wire logic [gpt_pkg::HALL_W-1:0] hallIn,
    input wire logic [gpt_pkg::HALL_W-1:0] hallEnable,
    input wire logic                       hallEvent,
    input wire logic [NUM_CH-1:0]          chPin,
    input wire logic [NUM_CH-1:0][CW-1:0]  chCapture,
    input wire logic [NUM_CH:0]            eventFlag,
    input wire logic [NUM_CH:0]            dmaEnable,
    input wire logic [NUM_CH:0]            dmaReq,
    // Status
    input wire logic [CW-1:0]              count,
    input wire logic                       running
);
    import gpt_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Plain counting from the main clock, no peer reset
    sequence sRun(gpt_cntmode_e m);
        countMode == m && slaveMode == GPT_SLV_OFF && !slowClockSel;
    endsequence
    // Rising pin edge on a capture channel
    sequence sCapRise;
        chMode[0] == GPT_CH_CAPTURE && chEdge[0] == GPT_EDGE_RISE && $rose(chPin[0]);
    endsequence
    a_up_step: assert property (sRun(GPT_CNT_UP) ##0 $changed(count) |->
        count == (($past(count) == $past(period)) ? '0 : $past(count) + 1'b1))
        else $error("up count step wrong");
    a_down_step: assert property (sRun(GPT_CNT_DOWN) ##0 $changed(count) |->
        count == (($past(count) == '0) ? $past(period) : $past(count) - 1'b1))
        else $error("down count step wrong");
    a_prescale_gap: assert property (sRun(GPT_CNT_UP) ##0 $changed(count)
        && prescale == 16'h0002 |=> $stable(count) ##1 $stable(count))
        else $error("prescaler gap wrong");
    a_freeze_holds: assert property (debugHalt && freezeOnHalt
        && slaveMode != GPT_SLV_RESET |=> $stable(count)) else $error("count moved when frozen");
    a_capture_copy: assert property (sCapRise |=> chCapture[0] == $past(count))
        else $error("capture value wrong");
    a_capture_flag: assert property (sCapRise |=> ##1 eventFlag[1])
        else $error("capture flag missing");
    a_one_pulse_stop: assert property (sRun(GPT_CNT_UP) ##0 onePulse && running
        && prescale == '0 && count == period && !debugHalt |-> ##[1:3] !running)
        else $error("one-pulse did not stop");
    a_hall_event: assert property (((hallIn ^ $past(hallIn)) & hallEnable) != '0
        && $stable(hallEnable) |-> ##[1:2] hallEvent) else $error("hall event missing");
    a_dma_with_flag: assert property ($rose(eventFlag[0]) && dmaEnable[0]
        && $stable(dmaEnable[0]) |-> dmaReq[0]) else $error("update request missing");
    a_slave_reset: assert property (slaveMode == GPT_SLV_RESET && $rose(triggerIn)
        |-> ##[1:2] count == ((countMode == GPT_CNT_DOWN) ? period : '0))
        else $error("peer reset ignored");
endmodule : gpt_timer_chk

bind gpt_timer gpt_timer_chk #(.CW(CW), .NUM_CH(NUM_CH)) u_chk (.clock, .reset, .onePulse,
    .countMode, .prescale, .period, .slowClockSel, .debugHalt, .freezeOnHalt, .slaveMode,
    .chMode, .chEdge, .triggerIn, .hallIn, .hallEnable, .hallEvent, .chPin, .chCapture,
    .eventFlag, .dmaEnable, .dmaReq, .count, .running);

// *** test/gpt_timer_tb.sv ***
// Purpose: Self-checking bench for the general purpose timer
// Assumes: Full-featured 16-bit variant, four channels
// Notes:   Every test starts from a fresh reset
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module gpt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpt_pkg::*;
    logic             clock = 1'b0, reset, startPulse, stopPulse, onePulse, slowClockSel;
    logic             slowCrystalClock, debugHalt, freezeOnHalt, triggerIn, triggerOutSel;
    logic             triggerOut, encA, encB, hallEvent, countingUp, running, stepUp, stepDn;
    logic             lastTog;
    gpt_cntmode_e     countMode;
    gpt_slave_e       slaveMode;
    gpt_chmode_e      chMode [4];
    gpt_edge_e        chEdge [4];
    logic [15:0]      prescale, period, count;
    logic [2:0]       hallIn, hallEnable;
    logic [3:0][15:0] chCompare, chCapture;
    logic [3:0]       chPin, chOut;
    logic [4:0]       flagClear, eventFlag, dmaEnable, dmaReq;
    int               num_errors = 0, num_checks = 0, tally [5];

    gpt_timer DUT (.clock, .reset, .startPulse, .stopPulse, .onePulse, .countMode, .prescale,
        .period, .slowClockSel, .slowCrystalClock, .debugHalt, .freezeOnHalt, .triggerIn,
        .slaveMode, .triggerOutSel, .triggerOut, .encA, .encB, .hallIn, .hallEnable,
        .hallEvent, .chMode, .chEdge, .chCompare, .chPin, .chOut, .chCapture, .flagClear,
        .eventFlag, .dmaEnable, .dmaReq, .count, .countingUp, .running);
    gpt_far_model u_far (.clock, .reset, .stepUp, .stepDn, .encA, .encB);

    // 25 MHz clock
    always #20 clock = ~clock;
    // Tallies output pulses on the settled half cycle
    always @(negedge clock) begin
        tally[0] += chOut[1];
        tally[1] += chOut[2];
        tally[2] += (chOut[3] !== lastTog);
        tally[3] += triggerOut;
        tally[4] += hallEvent;
        lastTog = chOut[3];
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic init(input gpt_cntmode_e cm, input logic [15:0] pr, input logic [15:0] pe);
        reset = 1'b1;
        {startPulse, stopPulse, onePulse, slowClockSel, slowCrystalClock, debugHalt} = '0;
        {freezeOnHalt, triggerIn, triggerOutSel, stepUp, stepDn, lastTog} = '0;
        {hallIn, hallEnable, chPin, flagClear, chCompare} = '0;
        dmaEnable = 5'h1F;
        chMode = '{default: GPT_CH_CAPTURE};
        chEdge = '{default: GPT_EDGE_RISE};
        slaveMode = GPT_SLV_OFF;
        countMode = cm;
        prescale = pr;
        period = pe;
        cyc(8);
        reset = 1'b0;
        cyc(1);
    endtask : init
    task automatic go;
        startPulse = 1'b1;
        cyc(1);
        startPulse = 1'b0;
    endtask : go
    task automatic wait_cnt(input logic [15:0] v);
        repeat (60) if (count !== v) cyc(1);
    endtask : wait_cnt
    task automatic step(input logic up);
        stepUp = up;
        stepDn = !up;
        cyc(1);
        {stepUp, stepDn} = 2'b00;
        cyc(6);
    endtask : step

    task automatic t_count;
        init(GPT_CNT_UP, 16'h0000, 16'h0002);
        go();
        wait_cnt(16'h0002);
        cyc(1);
        `CHK(count, 16'h0000)
        cyc(1);
        `CHK(dmaReq[0], 1'b1)
        `CHK(eventFlag[0], 1'b1)
        init(GPT_CNT_DOWN, 16'h0000, 16'h0003);
        go();
        wait_cnt(16'h0003);
        cyc(1);
        `CHK(count, 16'h0002)
        init(GPT_CNT_CENTER, 16'h0000, 16'h0003);
        go();
        wait_cnt(16'h0003);
        cyc(1);
        `CHK(count, 16'h0002)
        `CHK(countingUp, 1'b0)
        $display("test count done");
    endtask : t_count
    task automatic t_clocking;
        init(GPT_CNT_UP, 16'h0002, 16'h0009);
        go();
        wait_cnt(16'h0001);
        cyc(2);
        `CHK(count, 16'h0001)
        cyc(1);
        `CHK(count, 16'h0002)
        init(GPT_CNT_UP, 16'h0000, 16'h0009);
        slowClockSel = 1'b1;
        go();
        cyc(10);
        `CHK(count, 16'h0000)
        repeat (3) begin
            slowCrystalClock = 1'b1;
            cyc(4);
            slowCrystalClock = 1'b0;
            cyc(4);
        end
        `CHK(count, 16'h0003)
        init(GPT_CNT_UP, 16'h0000, 16'h0064);
        go();
        wait_cnt(16'h0005);
        {debugHalt, freezeOnHalt} = 2'b11;
        cyc(10);
        `CHK(count, 16'h0005)
        debugHalt = 1'b0;
        cyc(3);
        `CHK(count, 16'h0008)
        $display("test clocking done");
    endtask : t_clocking
    task automatic t_enc_cap;
        init(GPT_CNT_ENC, 16'h0000, 16'h0064);
        go();
        repeat (4) step(1'b1);
        `CHK(count, 16'h0004)
        step(1'b0);
        `CHK(count, 16'h0003)
        triggerOutSel = 1'b1;
        tally = '{default: 0};
        chPin[0] = 1'b1;
        cyc(3);
        `CHK(chCapture[0], 16'h0003)
        `CHK(eventFlag[1], 1'b1)
        `CHK(tally[3], 1)
        flagClear[1] = 1'b1;
        cyc(1);
        flagClear[1] = 1'b0;
        cyc(1);
        `CHK(eventFlag[1], 1'b0)
        chEdge[0] = GPT_EDGE_FALL;
        chPin[0] = 1'b0;
        cyc(3);
        `CHK(eventFlag[1], 1'b1)
        $display("test encoder capture done");
    endtask : t_enc_cap
    task automatic t_outputs;
        init(GPT_CNT_UP, 16'h0000, 16'h0004);
        chMode[2] = GPT_CH_PWM;
        chMode[3] = GPT_CH_COMPARE;
        chCompare[2] = 16'h0002;
        chCompare[3] = 16'h0001;
        go();
        cyc(6);
        tally = '{default: 0};
        cyc(10);
        `CHK(tally[1], 4)
        `CHK(tally[2], 2)
        init(GPT_CNT_UP, 16'h0000, 16'h0003);
        onePulse = 1'b1;
        chMode[1] = GPT_CH_PULSE;
        chCompare[1] = 16'h0001;
        tally = '{default: 0};
        go();
        cyc(12);
        `CHK(tally[0], 3)
        `CHK(running, 1'b0)
        $display("test outputs done");
    endtask : t_outputs
    task automatic t_link;
        init(GPT_CNT_UP, 16'h0000, 16'h0003);
        slaveMode = GPT_SLV_START;
        triggerIn = 1'b1;
        cyc(3);
        `CHK(running, 1'b1)
        tally = '{default: 0};
        cyc(8);
        `CHK(tally[3], 2)
        wait_cnt(16'h0002);
        stopPulse = 1'b1;
        triggerIn = 1'b0;
        slaveMode = GPT_SLV_RESET;
        cyc(1);
        stopPulse = 1'b0;
        cyc(2);
        triggerIn = 1'b1;
        cyc(3);
        `CHK(count, 16'h0000)
        hallEnable = 3'b011;
        cyc(2);
        tally = '{default: 0};
        hallIn = 3'b100;
        cyc(3);
        `CHK(tally[4], 0)
        hallIn = 3'b101;
        cyc(3);
        `CHK(tally[4], 1)
        slaveMode = GPT_SLV_GATED;
        triggerIn = 1'b0;
        go();
        cyc(3);
        `CHK(count, 16'h0000)
        triggerIn = 1'b1;
        cyc(2);
        `CHK(count, 16'h0002)
        $display("test link hall done");
    endtask : t_link

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        t_count();
        t_clocking();
        t_enc_cap();
        t_outputs();
        t_link();
        finish_test();
    end
    // Watchdog
    initial begin
        #(40 * 5000);
        num_errors++;
        $display("watchdog expired");
        finish_test();
    end
endmodule : gpt_timer_tb
